// [verilog/sacl_control.sv]
// Control logic of a successive-approximation converter with an APB register slave.
//
// Function
// [R1] Converter disabled during reset and whenever channel select is all ones.
// [R2] A write to status_control_one aborts and restarts conversion unless channel is off.
// [R3] After completion with no new start the block sits idle at lowest power.
// [R4] Sequence yields twelve raw bits in 12/10-bit modes, nine in 8-bit mode.
// [R5] 10-bit result rounded across both result registers; 8-bit rounded into low only.
// [R6] Result stored, then complete flag set; interrupt raised when completion enable is one.
// [R7] With compare enabled every result is compared against the compare value registers.
// [R8] Clock source picks bus, bus halved, local async clock or alternate clock input.
// [R9] After reset the clock source is the undivided bus clock.
// [R10] Source passes a divider by one to eight; with bus halved total reaches 16.
// [R11] Alternate clock input stays usable as conversion clock in wait mode.
// [R12] Alternate clock input is not usable as conversion clock in stop3.
// [R13] Hardware trigger starts a conversion each time counter value equals modulo value.
// [R14] Counter trigger starts conversions in run, wait and stop3.
// [R15] Pin control bits 0..3 disable digital I/O of inputs 16..19 when one.
// [R16] Channel select routes any of up to 28 analog inputs.
// [R17] Software sets the bandgap buffer enable before selecting the bandgap channel.
// [R18] Clock source field is two bits, zero selecting the undivided bus clock.
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module sacl_control
  import sacl_pkg::*;
#(
  parameter int SAMPLE_TICKS = SAMPLE_TICKS_DEFAULT
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        local_async_clock,
  input  wire logic        alternate_clock_input,
  input  wire logic        sys_wait,
  input  wire logic        sys_stop3,
  input  wire logic [15:0] rtc_count_value,
  input  wire logic [15:0] rtc_modulo_value,
  input  wire logic        comparator_high,
  output logic             converter_enable,
  output logic             sample_hold,
  output logic      [4:0]  channel_out,
  output logic      [11:0] dac_code,
  output logic      [3:0]  pin_digital_disable,
  output logic             irq
);

  initial begin
    if (SAMPLE_TICKS < 1 || SAMPLE_TICKS > 255) begin
      $error("sacl_control: SAMPLE_TICKS must lie in 1..255");
    end
  end

  localparam logic [7:0] SAMPLE_LAST = 8'(SAMPLE_TICKS - 1);

  sacl_state_t s;
  sacl_state_t next_s;

  // Returns 1 when the byte address hits a mapped register.
  function automatic logic addr_valid(input logic [7:0] a);
    if (a == OFF_STATUS_CONTROL_ONE) begin
      addr_valid = 1'b1;
    end else if (a == OFF_STATUS_CONTROL_TWO) begin
      addr_valid = 1'b1;
    end else if (a == OFF_RESULT_HIGH || a == OFF_RESULT_LOW) begin
      addr_valid = 1'b1;
    end else if (a == OFF_COMPARE_VALUE_HIGH || a == OFF_COMPARE_VALUE_LOW) begin
      addr_valid = 1'b1;
    end else if (a == OFF_CONFIG || a == OFF_ANALOG_PIN_CONTROL_HI) begin
      addr_valid = 1'b1;
    end else if (a == OFF_IRQ_STATUS || a == OFF_IRQ_MASK) begin
      addr_valid = 1'b1;
    end else begin
      addr_valid = 1'b0;
    end
  endfunction : addr_valid

  // Read value of a register, zero above its width and for unmapped addresses.
  function automatic logic [31:0] read_value(input sacl_state_t r, input logic [7:0] a);
    read_value = 32'h0;
    if (a == OFF_STATUS_CONTROL_ONE) begin
      read_value[SC1_CONVERSION_COMPLETE_FLAG_BIT] = r.conversion_complete_flag;
      read_value[SC1_COMPLETE_IRQ_ENABLE_BIT] = r.complete_irq_enable;
      read_value[4:0]          = r.channel_select;
    end else if (a == OFF_STATUS_CONTROL_TWO) begin
      read_value[SC2_ACTIVE_BIT] = (r.phase != SACL_IDLE);
      read_value[SC2_TRIG_BIT]   = r.hw_trigger_select;
      read_value[SC2_COMPARE_FUNCTION_ENABLE_BIT]   = r.compare_function_enable;
      read_value[SC2_ACFGT_BIT]  = r.compare_greater;
    end else if (a == OFF_RESULT_HIGH) begin
      read_value[3:0] = r.result_high;
    end else if (a == OFF_RESULT_LOW) begin
      read_value[7:0] = r.result_low;
    end else if (a == OFF_COMPARE_VALUE_HIGH) begin
      read_value[3:0] = r.compare_value_high;
    end else if (a == OFF_COMPARE_VALUE_LOW) begin
      read_value[7:0] = r.compare_value_low;
    end else if (a == OFF_CONFIG) begin
      read_value[6:5] = r.clock_divide_field;
      read_value[3:2] = r.mode;
      read_value[1:0] = r.clock_source_field;
    end else if (a == OFF_ANALOG_PIN_CONTROL_HI) begin
      read_value[3:0] = r.analog_pin_control_hi;
    end else if (a == OFF_IRQ_STATUS) begin
      read_value[1:0] = r.irq_status;
    end else if (a == OFF_IRQ_MASK) begin
      read_value[1:0] = r.irq_mask;
    end
  endfunction : read_value

  // Rounds the raw code to the width of the mode; saturates instead of wrapping at full scale.
  function automatic logic [11:0] round_result(input logic [1:0] m, input logic [11:0] raw);
    logic [12:0] sum10;
    logic [9:0]  sum8;
    sum10 = {1'b0, raw} + 13'h002;
    sum8  = {1'b0, raw[8:0]} + 10'h001;
    if (m == MODE_10BIT) begin
      round_result = sum10[12] ? 12'h3ff : {2'h0, sum10[11:2]};
    end else if (m == MODE_8BIT) begin
      round_result = sum8[9] ? 12'h0ff : {4'h0, sum8[8:1]};
    end else begin
      round_result = raw;
    end
  endfunction : round_result

  logic        access;
  logic        wr;
  logic        rd;
  logic        src_tick;
  logic [2:0]  div_last;
  logic        conv_tick;
  logic        rtc_match;
  logic        hw_start;
  logic        sw_start;
  logic        start;
  logic        disabled;
  logic        ev_complete;
  logic        ev_match;
  logic [11:0] kept;
  logic [11:0] rounded;
  logic        cmp_ok;

  assign access = psel && penable;
  assign wr     = access && pwrite && pstrb[0];
  assign rd     = access && !pwrite;

  always_comb begin
    next_s      = s;
    ev_complete = 1'b0;
    ev_match    = 1'b0;
    kept        = 12'h0;
    rounded     = 12'h0;
    cmp_ok      = 1'b0;
    disabled    = (s.channel_select == CHANNEL_OFF); // [R1]

    // Conversion clock as a tick enable on pclk; bus-derived sources stop in stop3 with the bus.
    next_s.half_toggle = !s.half_toggle;
    case (s.clock_source_field) // [R8] [R18]
      CLK_SRC_BUS:      src_tick = !sys_stop3;
      CLK_SRC_BUS_HALF: src_tick = !sys_stop3 && s.half_toggle;
      CLK_SRC_LOCAL:    src_tick = local_async_clock;
      default:          src_tick = alternate_clock_input && !sys_stop3; // [R11] [R12]
    endcase
    div_last  = 3'((4'h1 << s.clock_divide_field) - 4'h1); // [R10]
    conv_tick = 1'b0;
    if (s.phase == SACL_IDLE) begin
      next_s.div_count = 3'h0;
    end else if (src_tick) begin
      if (s.div_count >= div_last) begin
        next_s.div_count = 3'h0;
        conv_tick        = 1'b1;
      end else begin
        next_s.div_count = s.div_count + 3'h1;
      end
    end

    // Counter match is edge detected so a match held for many cycles starts one conversion.
    rtc_match         = (rtc_count_value == rtc_modulo_value);
    next_s.match_prev = rtc_match;
    hw_start = s.hw_trigger_select && rtc_match && !s.match_prev; // [R13] [R14]
    sw_start = wr && (paddr == OFF_STATUS_CONTROL_ONE) && (pwdata[4:0] != CHANNEL_OFF); // [R2]
    start    = sw_start || (hw_start && !disabled);

    // Conversion sequencer.
    case (s.phase)
      SACL_IDLE: begin
        next_s.trial = 12'h0; // [R3]
      end
      SACL_SAMPLE: begin
        if (conv_tick) begin
          if (s.sample_count >= SAMPLE_LAST) begin
            next_s.phase    = SACL_CONVERT;
            next_s.trial    = s.bit_mask;
            next_s.sample_count = 8'h0;
          end else begin
            next_s.sample_count = s.sample_count + 8'h1;
          end
        end
      end
      default: begin
        if (conv_tick) begin
          kept = comparator_high ? s.trial : (s.trial & ~s.bit_mask);
          if (s.bit_mask[0]) begin // [R4]
            rounded = round_result(s.mode, kept);
            if ({s.compare_value_high, s.compare_value_low} <= rounded) begin
              cmp_ok = s.compare_greater;
            end else begin
              cmp_ok = !s.compare_greater;
            end
            if (!s.compare_function_enable || cmp_ok) begin // [R7]
              next_s.result_high = (s.mode == MODE_8BIT) ? 4'h0 : rounded[11:8]; // [R5]
              next_s.result_low  = rounded[7:0]; // [R5]
              ev_complete        = 1'b1; // [R6]
              ev_match           = s.compare_function_enable; // [R7]
            end
            next_s.phase = SACL_IDLE; // [R3]
            next_s.trial = 12'h0;
          end else begin
            next_s.bit_mask = s.bit_mask >> 1;
            next_s.trial    = kept | (s.bit_mask >> 1);
          end
        end
      end
    endcase

    // Register writes land at the access edge; pstrb[0] covers every implemented field.
    if (wr) begin
      if (paddr == OFF_STATUS_CONTROL_ONE) begin
        next_s.channel_select      = pwdata[4:0]; // [R16]
        next_s.complete_irq_enable = pwdata[SC1_COMPLETE_IRQ_ENABLE_BIT];
        next_s.conversion_complete_flag = 1'b0;
        next_s.phase = SACL_IDLE; // [R2]
      end else if (paddr == OFF_STATUS_CONTROL_TWO) begin
        next_s.hw_trigger_select       = pwdata[SC2_TRIG_BIT];
        next_s.compare_function_enable = pwdata[SC2_COMPARE_FUNCTION_ENABLE_BIT];
        next_s.compare_greater         = pwdata[SC2_ACFGT_BIT];
      end else if (paddr == OFF_COMPARE_VALUE_HIGH) begin
        next_s.compare_value_high = pwdata[3:0];
      end else if (paddr == OFF_COMPARE_VALUE_LOW) begin
        next_s.compare_value_low = pwdata[7:0];
      end else if (paddr == OFF_CONFIG) begin
        next_s.clock_divide_field = pwdata[6:5];
        next_s.mode               = pwdata[3:2];
        next_s.clock_source_field = pwdata[1:0];
      end else if (paddr == OFF_ANALOG_PIN_CONTROL_HI) begin
        next_s.analog_pin_control_hi = pwdata[3:0];
      end else if (paddr == OFF_IRQ_MASK) begin
        next_s.irq_mask = pwdata[1:0];
      end
    end

    // Reading the low result acknowledges completion; a completion in that same cycle wins.
    if (rd && paddr == OFF_RESULT_LOW) begin
      next_s.conversion_complete_flag = 1'b0;
    end
    if (rd && paddr == OFF_IRQ_STATUS) begin
      next_s.irq_status = 2'h0;
    end
    if (ev_complete) begin
      next_s.conversion_complete_flag = 1'b1; // [R6]
      if (s.complete_irq_enable) begin
        next_s.irq_status[IRQ_COMPLETE_BIT] = 1'b1; // [R6]
      end
    end
    if (ev_match) begin
      next_s.irq_status[IRQ_MATCH_BIT] = 1'b1;
    end

    // A start aborts whatever runs and begins sampling afresh.
    if (start) begin
      next_s.phase        = SACL_SAMPLE;
      next_s.sample_count = 8'h0;
      next_s.div_count    = 3'h0;
      next_s.trial        = 12'h0;
      next_s.bit_mask     = (s.mode == MODE_8BIT) ? MSB_MASK_9 : MSB_MASK_12; // [R4]
    end
    if (next_s.channel_select == CHANNEL_OFF) begin
      next_s.phase = SACL_IDLE; // [R1]
    end

    // Read data is captured in the setup cycle so prdata comes from a flip-flop.
    if (psel && !penable) begin
      next_s.prdata = read_value(s, paddr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s                    <= '0;
      s.channel_select     <= RESET_CHANNEL; // [R1]
      s.clock_source_field <= RESET_CLK_SRC; // [R9]
      s.clock_divide_field <= RESET_CLK_DIV;
      s.mode               <= RESET_MODE;
      s.phase              <= SACL_IDLE;
      s.bit_mask           <= MSB_MASK_12;
    end else begin
      s <= next_s;
    end
  end

  assign prdata              = s.prdata;
  assign pready              = access;
  assign pslverr             = access && !addr_valid(paddr);
  assign converter_enable    = (s.phase != SACL_IDLE); // [R1] [R3]
  assign sample_hold         = (s.phase == SACL_SAMPLE);
  assign channel_out         = s.channel_select; // [R16]
  assign dac_code            = s.trial;
  assign pin_digital_disable = s.analog_pin_control_hi; // [R15]
  assign irq                 = |(s.irq_status & s.irq_mask);

endmodule : sacl_control

// [common/sacl_pkg.sv]
// Package for the converter control block: register map, field layout, reset values, types.
package sacl_pkg;

  localparam logic [7:0] OFF_STATUS_CONTROL_ONE   = 8'h00;
  localparam logic [7:0] OFF_STATUS_CONTROL_TWO   = 8'h04;
  localparam logic [7:0] OFF_RESULT_HIGH          = 8'h08;
  localparam logic [7:0] OFF_RESULT_LOW           = 8'h0c;
  localparam logic [7:0] OFF_COMPARE_VALUE_HIGH   = 8'h10;
  localparam logic [7:0] OFF_COMPARE_VALUE_LOW    = 8'h14;
  localparam logic [7:0] OFF_CONFIG               = 8'h18;
  localparam logic [7:0] OFF_ANALOG_PIN_CONTROL_HI = 8'h1c;
  localparam logic [7:0] OFF_IRQ_STATUS           = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASK             = 8'h24;

  localparam int SC1_CONVERSION_COMPLETE_FLAG_BIT = 7;
  localparam int SC1_COMPLETE_IRQ_ENABLE_BIT = 6;
  localparam int SC2_ACTIVE_BIT = 7;
  localparam int SC2_TRIG_BIT = 6;
  localparam int SC2_COMPARE_FUNCTION_ENABLE_BIT = 5;
  localparam int SC2_ACFGT_BIT = 4;
  localparam int IRQ_COMPLETE_BIT = 0;
  localparam int IRQ_MATCH_BIT = 1;

  localparam logic [4:0] CHANNEL_OFF     = 5'h1f;
  localparam logic [4:0] RESET_CHANNEL   = 5'h1f;
  localparam logic [1:0] RESET_CLK_SRC   = 2'h0;
  localparam logic [1:0] RESET_CLK_DIV   = 2'h0;

  localparam logic [1:0] CLK_SRC_BUS     = 2'h0;
  localparam logic [1:0] CLK_SRC_BUS_HALF = 2'h1;
  localparam logic [1:0] CLK_SRC_LOCAL   = 2'h2;
  localparam logic [1:0] CLK_SRC_ALT     = 2'h3;

  localparam logic [1:0] MODE_8BIT       = 2'h0;
  localparam logic [1:0] MODE_12BIT      = 2'h1;
  localparam logic [1:0] MODE_10BIT      = 2'h2;
  localparam logic [1:0] RESET_MODE      = 2'h0;

  localparam logic [11:0] MSB_MASK_12    = 12'h800;
  localparam logic [11:0] MSB_MASK_9     = 12'h100;
  localparam int          SAMPLE_TICKS_DEFAULT = 4;

  typedef enum logic [1:0] {
    SACL_IDLE,
    SACL_SAMPLE,
    SACL_CONVERT
  } sacl_phase_t;

  typedef struct packed {
    logic [4:0]  channel_select;
    logic        complete_irq_enable;
    logic        conversion_complete_flag;
    logic        hw_trigger_select;
    logic        compare_function_enable;
    logic        compare_greater;
    logic [3:0]  result_high;
    logic [7:0]  result_low;
    logic [3:0]  compare_value_high;
    logic [7:0]  compare_value_low;
    logic [1:0]  clock_divide_field;
    logic [1:0]  mode;
    logic [1:0]  clock_source_field;
    logic [3:0]  analog_pin_control_hi;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;
    sacl_phase_t phase;
    logic        half_toggle;
    logic [2:0]  div_count;
    logic [7:0]  sample_count;
    logic [11:0] trial;
    logic [11:0] bit_mask;
    logic        match_prev;
    logic [31:0] prdata;
  } sacl_state_t;

endpackage : sacl_pkg

// [verif/sacl_props.sv]
// Port-level checker for the converter control block.
`timescale 1ns/1ps
module sacl_props
  import sacl_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] rtc_count_value,
  input wire logic [15:0] rtc_modulo_value,
  input wire logic        converter_enable,
  input wire logic        sample_hold,
  input wire logic [4:0]  channel_out,
  input wire logic [11:0] dac_code,
  input wire logic [3:0]  pin_digital_disable,
  input wire logic        irq
);
  logic acc;
  logic sc1_wr;
  logic rtc_eq;
  assign acc    = psel && penable;
  assign sc1_wr = acc && pwrite && pstrb[0] && paddr == OFF_STATUS_CONTROL_ONE;
  assign rtc_eq = rtc_count_value == rtc_modulo_value;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  bus_ready_a: assert property (acc |-> pready) else $error("pready missing in access phase");
  bus_slverr_a: assert property (acc |-> pslverr == (paddr > OFF_IRQ_MASK)) else $error("pslverr wrong");
  chan_route_a: assert property (sc1_wr |=> {27'h0, channel_out} == ($past(pwdata) & 32'h1f))
    else $error("channel_out not updated");
  restart_a: assert property (sc1_wr && pwdata[4:0] != CHANNEL_OFF |=> converter_enable && sample_hold)
    else $error("conversion not restarted");
  chan_off_a: assert property (channel_out == CHANNEL_OFF && !sc1_wr |=> !converter_enable)
    else $error("converter runs with channel off");
  idle_hold_a: assert property (!converter_enable && !sc1_wr && !rtc_eq && !$past(rtc_eq) |=> !converter_enable)
    else $error("converter woke without a start");
  pin_ctl_a: assert property (acc && pwrite && pstrb[0] && paddr == OFF_ANALOG_PIN_CONTROL_HI
    |=> {28'h0, pin_digital_disable} == ($past(pwdata) & 32'hf)) else $error("pin control not applied");
  irq_clear_a: assert property (acc && !pwrite && paddr == OFF_IRQ_STATUS |=> !irq)
    else $error("irq stayed after status read");
  sar_start_a: assert property ($fell(sample_hold) && converter_enable |-> dac_code == MSB_MASK_12
    || dac_code == MSB_MASK_9) else $error("first trial code wrong");
endmodule : sacl_props

bind sacl_control sacl_props sacl_props_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
  .rtc_count_value(rtc_count_value), .rtc_modulo_value(rtc_modulo_value), .converter_enable(converter_enable),
  .sample_hold(sample_hold), .channel_out(channel_out), .dac_code(dac_code),
  .pin_digital_disable(pin_digital_disable), .irq(irq));

// [verif/sacl_far.sv]
// Far-side model: analog comparator, counter trigger source and the two slow clock sources.
`timescale 1ns/1ps
module sacl_far
  import sacl_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] vin,
  input  wire logic [15:0] rtc_modulo_value,
  input  wire logic [11:0] dac_code,
  output logic             comparator_high,
  output logic      [15:0] rtc_count_value,
  output logic             local_async_clock,
  output logic             alternate_clock_input
);
  logic [1:0] alt_div;
  assign comparator_high = vin >= dac_code;
  // Ticks run at a half and a third of the bus rate so the two sources are told apart.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rtc_count_value       <= 16'h0000;
      local_async_clock     <= 1'b0;
      alt_div               <= 2'h0;
      alternate_clock_input <= 1'b0;
    end else begin
      rtc_count_value       <= (rtc_count_value >= rtc_modulo_value) ? 16'h0000 : rtc_count_value + 16'h0001;
      local_async_clock     <= !local_async_clock;
      alt_div               <= (alt_div == 2'h2) ? 2'h0 : alt_div + 2'h1;
      alternate_clock_input <= alt_div == 2'h2;
    end
  end
endmodule : sacl_far

// [verif/sacl_control_tb.sv]
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
module sacl_control_tb
  import sacl_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, sys_wait, sys_stop3;
  logic        pready, pslverr, lck, alck, cmp, cen, shold, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb, pin_dis;
  logic [4:0]  ch_out;
  logic [11:0] dac, vin;
  logic [15:0] rcnt, rmod;
  logic [32:0] exq[$];
  logic [32:0] ent;
  logic [1:0]  modes[3] = '{MODE_12BIT, MODE_10BIT, MODE_8BIT};
  int          fail_count, n_tests, seed;

  sacl_control #(.SAMPLE_TICKS(4)) sacl_control_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .local_async_clock(lck), .alternate_clock_input(alck),
    .sys_wait(sys_wait), .sys_stop3(sys_stop3), .rtc_count_value(rcnt), .rtc_modulo_value(rmod),
    .comparator_high(cmp), .converter_enable(cen), .sample_hold(shold), .channel_out(ch_out),
    .dac_code(dac), .pin_digital_disable(pin_dis), .irq(irq));
  sacl_far sacl_far_inst (.pclk(pclk), .presetn(presetn), .vin(vin), .rtc_modulo_value(rmod), .dac_code(dac),
    .comparator_high(cmp), .rtc_count_value(rcnt), .local_async_clock(lck), .alternate_clock_input(alck));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask : check

  task automatic end_sim();
    if (fail_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  // Expected read data is queued at setup; the monitor pops it at the accepting edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    if (!w) exq.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      fail_count++;
      end_sim();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask : rd

  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && exq.size() > 0) begin
      ent = exq.pop_front();
      check("prdata", ent[31:0], prdata);
      check("pslverr", {31'h0, ent[32]}, {31'h0, pslverr});
    end
  end

  task automatic wait_irq(output int n);
    n = 0;
    while (irq !== 1'b1) begin
      @(posedge pclk);
      n++;
      if (n > 3000) begin
        fail_count++;
        end_sim();
      end
    end
  endtask : wait_irq

  function automatic logic [11:0] exp_res(input logic [1:0] m, input logic [11:0] v);
    logic [12:0] t;
    t = (m == MODE_8BIT) ? ((v > 12'h1ff ? 13'h1ff : {1'b0, v}) + 13'h1) >> 1 : ({1'b0, v} + 13'h2) >> 2;
    if (m == MODE_12BIT) return v;
    if (m == MODE_10BIT) return t > 13'h3ff ? 12'h3ff : t[11:0];
    return t > 13'h0ff ? 12'h0ff : t[11:0];
  endfunction : exp_res

  task automatic conv(input logic [6:0] cfg, input logic [4:0] ch, input logic [11:0] v, input logic [1:0] ei,
                      output int n);
    logic [11:0] r;
    r = exp_res(cfg[3:2], v);
    // Every call starts on a rising edge, so the analog level moves only there.
    vin <= v;
    wr(OFF_CONFIG, {25'h0, cfg});
    wr(OFF_STATUS_CONTROL_ONE, {24'h0, 3'h2, ch});
    wait_irq(n);
    rd(OFF_RESULT_HIGH, {21'h0, r[11:8]});
    rd(OFF_RESULT_LOW, {25'h0, r[7:0]});
    rd(OFF_IRQ_STATUS, {31'h0, ei});
    @(negedge pclk);
    check("irq", 32'h0, {31'h0, irq});
    check("channel_out", {27'h0, ch}, {27'h0, ch_out});
    // Return on a rising edge so the caller's next stimulus lands there.
    @(posedge pclk);
  endtask : conv

  initial begin
    int          n;
    logic [31:0] r;
    seed = 32'h5f5e54ee;
    {psel, penable, pwrite, sys_wait, sys_stop3} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    vin = 12'h000;
    rmod = 16'h0032;
    presetn = 1'b0;
    fail_count = 0;
    n_tests = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      rd(8'(i * 4), {i == 10, i == 0 ? 32'h1f : 32'h0});
    end
    r = $random(seed);
    wr(OFF_ANALOG_PIN_CONTROL_HI, r);
    @(negedge pclk);
    check("pin_digital_disable", {28'h0, r[3:0]}, {28'h0, pin_dis});
    rd(OFF_ANALOG_PIN_CONTROL_HI, {29'h0, r[3:0]});
    wr(OFF_IRQ_MASK, 32'h3);
    for (int p = 0; p < 2; p++) begin
      foreach (modes[j]) begin
        r = $random(seed);
        conv({3'h0, modes[j], RESET_CLK_SRC}, r[20:16] % 5'd28, p ? r[11:0] : 12'hfff, 2'h1, n);
        check("bus_cycles", 32'h1, {31'h0, n <= 24});
      end
    end
    conv({2'h3, 1'b0, MODE_12BIT, CLK_SRC_BUS_HALF}, 5'h03, 12'h5a5, 2'h1, n);
    check("div16_cycles", 32'h1, {31'h0, n >= 240});
    conv({3'h0, MODE_12BIT, CLK_SRC_LOCAL}, 5'h1b, 12'h3c3, 2'h1, n);
    sys_wait <= 1'b1;
    conv({3'h0, MODE_12BIT, CLK_SRC_ALT}, 5'h05, 12'h3c3, 2'h1, n);
    sys_wait <= 1'b0;
    sys_stop3 <= 1'b1;
    wr(OFF_STATUS_CONTROL_ONE, 32'h45);
    repeat (200) @(posedge pclk);
    rd(OFF_STATUS_CONTROL_ONE, 33'h45);
    sys_stop3 <= 1'b0;
    wait_irq(n);
    rd(OFF_RESULT_LOW, 33'hc3);
    rd(OFF_IRQ_STATUS, 33'h1);
    wr(OFF_STATUS_CONTROL_ONE, 32'h42);
    wr(OFF_STATUS_CONTROL_ONE, 32'h1f);
    @(negedge pclk);
    check("converter_enable", 32'h0, {31'h0, cen});
    rd(OFF_STATUS_CONTROL_TWO, 33'h0);
    // A failing compare must leave no flag, so the pass case follows on the same settings.
    wr(OFF_COMPARE_VALUE_HIGH, 32'h8);
    wr(OFF_COMPARE_VALUE_LOW, 32'h0);
    wr(OFF_STATUS_CONTROL_TWO, 32'h30);
    wr(OFF_CONFIG, 32'h4);
    vin <= 12'h100;
    wr(OFF_STATUS_CONTROL_ONE, 32'h47);
    repeat (60) @(posedge pclk);
    rd(OFF_STATUS_CONTROL_ONE, 33'h47);
    conv({3'h0, MODE_12BIT, CLK_SRC_BUS}, 5'h07, 12'h900, 2'h3, n);
    wr(OFF_CONFIG, {25'h0, 3'h0, MODE_12BIT, CLK_SRC_LOCAL});
    sys_stop3 <= 1'b1;
    wr(OFF_STATUS_CONTROL_TWO, 32'h40);
    wait_irq(n);
    rd(OFF_IRQ_STATUS, 33'h1);
    wr(OFF_STATUS_CONTROL_TWO, 32'h0);
    sys_stop3 <= 1'b0;
    end_sim();
  end
endmodule : sacl_control_tb
